// ---- verilog/serial_flash_command_decoder.sv ----
// Serial flash opcode decoder: phases, lanes, addressing and dispatch
`timescale 1ns/100ps
module serial_flash_command_decoder (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Flash pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   // Configuration and array status
   input wire logic dummy_cfg_lo,
   input wire logic dummy_cfg_hi,
   input wire logic enter_wide_address_mode,
   input wire logic busy,
   output logic quad_command_mode,
   // Dispatched operations
   output logic op_valid,
   output logic [2:0] op_kind,
   output logic [31:0] op_addr,
   output logic cmd_reject,
   // Read data from the array
   input wire logic [7:0] rd_data,
   output logic rd_next,
   // Program data toward the page buffer
   output logic prog_valid,
   output logic [7:0] prog_data,
   input wire logic prog_ready
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_DUMMY, S_RDATA, S_WDATA, S_END,
      S_STBY} state_e;

   typedef struct packed {
      state_e state;
      logic quad;
      fcd_pkg::cmd_s cmd;
      logic [31:0] sh;
      logic [31:0] addr;
      logic [5:0] nbits;
      logic [5:0] need;
      logic [4:0] dcnt;
      logic [8:0] bcnt;
      logic overrun;
      logic [7:0] obyte;
      logic [3:0] obits;
      logic [3:0] io_out;
      logic [3:0] io_oe;
      logic op_valid;
      logic [2:0] op_kind;
      logic [31:0] op_addr;
      logic rd_next;
      logic cmd_reject;
      logic push;
      logic [7:0] push_data;
   } dec_s;

   dec_s st;
   dec_s n;
   link_ev_if lk();
   logic fifo_in_ready;
   logic [1:0] dummy_cfg;
   logic [2:0] w_in;
   logic [31:0] sh_in;
   logic [5:0] nb;
   logic in_edge;
   logic out_edge;
   logic bad;
   logic go_read;
   logic [7:0] ob;
   logic [11:0] step;
   fcd_pkg::cmd_s dec;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [3:0] io,
      input logic [2:0] w);
      case (w)
         3'h4: shift_in = {v[27:0], io};
         3'h2: shift_in = {v[29:0], io[1:0]};
         default: shift_in = {v[30:0], io[0]};
      endcase
   endfunction : shift_in

   // Lanes to drive, then the byte left over
   function automatic logic [11:0] out_step(input logic [7:0] b, input logic [2:0] w);
      case (w)
         3'h4: out_step = {b[7:4], b[3:0], 4'h0};
         3'h2: out_step = {2'h0, b[7:6], b[5:0], 2'h0};
         default: out_step = {2'h0, b[7], 1'b0, b[6:0], 1'b0};
      endcase
   endfunction : out_step

   function automatic logic [3:0] lane_mask(input logic [2:0] w);
      case (w)
         3'h4: lane_mask = 4'hf;
         3'h2: lane_mask = 4'h3;
         default: lane_mask = 4'h2;
      endcase
   endfunction : lane_mask

   ////////////////////////////////////////////////////////////////////////////////
   link_sampler u_samp (
      .clk_sys(clk_sys),
      .reset(reset),
      .sclk(sclk),
      .cs_n(cs_n),
      .io_in(io_in),
      .ev(lk.src)
   );

   // Program data is staged here so a slow page buffer can trail the link
   word_fifo #(
      .WIDTH(8),
      .DEPTH(8)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(st.push),
      .in_ready(fifo_in_ready),
      .in_data(st.push_data),
      .out_valid(prog_valid),
      .out_ready(prog_ready),
      .out_data(prog_data)
   );

   assign dummy_cfg = {dummy_cfg_hi, dummy_cfg_lo};

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      n = st;
      n.op_valid = 1'b0;
      n.rd_next = 1'b0;
      n.cmd_reject = 1'b0;
      n.push = 1'b0;
      go_read = 1'b0;
      if (st.state == S_OPC)
         w_in = st.quad ? 3'h4 : 3'h1;
      else if (st.state == S_ADDR)
         w_in = st.cmd.alane;
      else
         w_in = st.cmd.dlane;
      sh_in = shift_in(st.sh, lk.io, w_in);
      nb = st.nbits + {3'h0, w_in};
      in_edge = lk.sclk_rise | (st.cmd.ddr & lk.sclk_fall & (st.state == S_ADDR));
      out_edge = lk.sclk_fall | (st.cmd.ddr & lk.sclk_rise);
      dec = fcd_pkg::decode(sh_in[7:0]);
      if (st.quad)
      begin
         dec.alane = 3'h4;
         dec.dlane = 3'h4;
      end
      bad = !dec.ok || (st.quad && !dec.quad_ok) || (busy && dec.cls != fcd_pkg::CL_MODE);
      ob = (st.obits == 4'h0) ? rd_data : st.obyte;
      step = out_step(ob, st.cmd.dlane);
      // A refused push spoils the page; the command is then rejected at its end
      if (st.push && !fifo_in_ready)
         n.overrun = 1'b1;
      if (lk.cs_rise)
      begin
         n.state = S_IDLE;
         n.io_oe = 4'h0;
         case (st.state)
            S_END:
               if (st.nbits[2:0] != 3'h0)
                  n.cmd_reject = 1'b1;
               else if (st.cmd.cls == fcd_pkg::CL_MODE)
                  n.quad = st.cmd.quad_on;
               else
               begin
                  n.op_valid = 1'b1;
                  n.op_kind = st.cmd.kind;
                  n.op_addr = st.addr;
               end
            S_WDATA:
               if (st.nbits != 6'h0 || st.bcnt == 9'h0 || n.overrun)
                  n.cmd_reject = 1'b1;
               else
               begin
                  n.op_valid = 1'b1;
                  n.op_kind = fcd_pkg::OPK_PROGRAM;
                  n.op_addr = st.addr;
               end
            S_ADDR:
               n.cmd_reject = st.cmd.cls != fcd_pkg::CL_READ;
            default:
               n.cmd_reject = 1'b0;
         endcase
      end
      else
      begin
         case (st.state)
            S_IDLE:
               if (lk.cs_fall)
               begin
                  n.state = S_OPC;
                  n.nbits = 6'h0;
                  n.sh = 32'h0;
                  n.io_oe = 4'h0;
               end
            S_OPC:
               if (in_edge)
               begin
                  n.sh = sh_in;
                  n.nbits = nb;
                  if (nb == fcd_pkg::BYTE_BITS)
                  begin
                     n.sh = 32'h0;
                     n.nbits = 6'h0;
                     n.cmd = dec;
                     n.addr = 32'h0;
                     n.need = (enter_wide_address_mode || dec.force4) ?
                        fcd_pkg::ADDR_BITS_LONG : fcd_pkg::ADDR_BITS_SHORT;
                     if (bad)
                        n.state = S_STBY;
                     else
                        n.state = dec.has_addr ? S_ADDR : S_END;
                  end
               end
            S_ADDR:
               if (in_edge)
               begin
                  n.sh = sh_in;
                  n.nbits = nb;
                  if (nb == st.need)
                  begin
                     n.addr = sh_in;
                     n.sh = 32'h0;
                     n.nbits = 6'h0;
                     if (st.cmd.cls == fcd_pkg::CL_READ)
                     begin
                        n.dcnt = fcd_pkg::dummy_count(dummy_cfg);
                        if (st.cmd.dummy)
                           n.state = S_DUMMY;
                        else
                           go_read = 1'b1;
                     end
                     else if (st.cmd.cls == fcd_pkg::CL_PROG)
                     begin
                        n.state = S_WDATA;
                        n.bcnt = 9'h0;
                        n.overrun = 1'b0;
                     end
                     else
                        n.state = S_END;
                  end
               end
            S_DUMMY:
               if (lk.sclk_rise)
               begin
                  n.dcnt = st.dcnt - 5'h1;
                  if (st.dcnt == 5'h1)
                     go_read = 1'b1;
               end
            S_RDATA:
               // Stream runs until select rises; each byte asks for the next
               if (out_edge)
               begin
                  if (st.obits == 4'h0)
                  begin
                     n.rd_next = 1'b1;
                     n.obits = 4'h8 - {1'b0, st.cmd.dlane};
                  end
                  else
                     n.obits = st.obits - {1'b0, st.cmd.dlane};
                  n.io_out = step[11:8];
                  n.obyte = step[7:0];
               end
            S_WDATA:
               if (in_edge)
               begin
                  n.sh = sh_in;
                  n.nbits = nb;
                  if (nb == fcd_pkg::BYTE_BITS)
                  begin
                     n.nbits = 6'h0;
                     // Bytes past one page are dropped, not wrapped
                     if (st.bcnt != fcd_pkg::PAGE_BYTES)
                     begin
                        n.push = 1'b1;
                        n.push_data = sh_in[7:0];
                        n.bcnt = st.bcnt + 9'h1;
                     end
                  end
               end
            S_END:
               if (in_edge)
                  n.nbits = {3'h0, nb[2:0]};
            S_STBY:
               n.io_oe = 4'h0;
            default:
               n.state = S_IDLE;
         endcase
         if (go_read)
         begin
            n.state = S_RDATA;
            n.op_valid = 1'b1;
            n.op_kind = fcd_pkg::OPK_READ;
            n.op_addr = n.addr;
            n.obits = 4'h0;
            n.io_oe = lane_mask(st.cmd.dlane);
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st <= '0;
         st.quad <= fcd_pkg::QUAD_RESET;
      end
      else
         st <= n;
   end

   assign io_out = st.io_out;
   assign io_oe = st.io_oe;
   assign quad_command_mode = st.quad;
   assign op_valid = st.op_valid;
   assign op_kind = st.op_kind;
   assign op_addr = st.op_addr;
   assign cmd_reject = st.cmd_reject;
   assign rd_next = st.rd_next;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_mode_commit;
      lk.cs_rise && st.state == S_END && st.nbits[2:0] == 3'h0 &&
         st.cmd.cls == fcd_pkg::CL_MODE;
   endsequence

   sequence s_opc_done;
      st.state == S_OPC ##1 (st.state == S_ADDR || st.state == S_END);
   endsequence

   property p_quad_enter;
      s_mode_commit ##0 st.cmd.quad_on |=> quad_command_mode && !op_valid;
   endproperty
   a_quad_enter: assert property (p_quad_enter) else $error("quad mode not entered");

   property p_quad_exit;
      s_mode_commit ##0 !st.cmd.quad_on |=> !quad_command_mode;
   endproperty
   a_quad_exit: assert property (p_quad_exit) else $error("quad mode not left");

   property p_dummy;
      st.state != S_DUMMY ##1 st.state == S_DUMMY |->
         st.dcnt == fcd_pkg::dummy_count($past(dummy_cfg));
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy count wrong");

   property p_addr_len;
      s_opc_done ##0 st.state == S_ADDR |-> st.need == ((st.cmd.force4 ||
         $past(enter_wide_address_mode)) ? fcd_pkg::ADDR_BITS_LONG : fcd_pkg::ADDR_BITS_SHORT);
   endproperty
   a_addr_len: assert property (p_addr_len) else $error("address length wrong");

   property p_force4;
      st.state == S_ADDR && st.cmd.force4 |-> st.need == fcd_pkg::ADDR_BITS_LONG;
   endproperty
   a_force4: assert property (p_force4) else $error("wide opcode short address");

   property p_read_oe;
      op_valid && op_kind == fcd_pkg::OPK_READ |-> io_oe != 4'h0 && st.state == S_RDATA;
   endproperty
   a_read_oe: assert property (p_read_oe) else $error("read started without drive");

   property p_drive_fall;
      st.state == S_RDATA && !st.cmd.ddr && $changed(io_out) |-> $past(lk.sclk_fall);
   endproperty
   a_drive_fall: assert property (p_drive_fall) else $error("output moved off fall");

   property p_reject;
      lk.cs_rise && st.state == S_END && st.nbits[2:0] != 3'h0 |=>
         cmd_reject && !op_valid && $stable(quad_command_mode);
   endproperty
   a_reject: assert property (p_reject) else $error("unaligned command executed");

   property p_standby;
      st.state == S_STBY && !lk.cs_rise |=> st.state == S_STBY && io_oe == 4'h0;
   endproperty
   a_standby: assert property (p_standby) else $error("standby left early");

   property p_busy;
      s_opc_done ##0 st.cmd.cls != fcd_pkg::CL_MODE |-> !$past(busy);
   endproperty
   a_busy: assert property (p_busy) else $error("array command taken while busy");

   property p_quad_only;
      quad_command_mode ##0 s_opc_done |-> st.cmd.quad_ok;
   endproperty
   a_quad_only: assert property (p_quad_only) else $error("single-line opcode in quad");
endmodule : serial_flash_command_decoder

// ---- verilog/fcd_pkg.sv ----
// Constants, types and opcode decode for the serial flash command decoder
// Operation
// - Opcode 35h enters quad command mode
// - Opcode F5h returns to single-line mode
// - Dummy cycles set by config bits 6, 7
// - Three address bytes, four in wide mode
// - Decode 03 0B 3B BB 6B EB reads
// - Page program takes 1 to 256 bytes
// - Quad page program: four lines, single-line only
// - Erase 4KB, 32KB, 64KB, plus wide variants
// - 60h or C7h erases whole chip
// - Quad mode: quad reads, program, erases, 35h/F5h only
// - Wide-address opcodes always take four bytes
// - Write-type commands must end on byte boundary
// - Unknown command: standby, outputs off till select
// - Sample on rising, drive on falling clock; DDR reads sample address and drive data on both edges
// - Ignore array commands while busy
package fcd_pkg;
   localparam logic [1:0] CL_READ = 2'h0;
   localparam logic [1:0] CL_PROG = 2'h1;
   localparam logic [1:0] CL_ERASE = 2'h2;
   localparam logic [1:0] CL_MODE = 2'h3;
   localparam logic [2:0] OPK_READ = 3'h1;
   localparam logic [2:0] OPK_PROGRAM = 3'h2;
   localparam logic [2:0] OPK_ERASE_4K = 3'h3;
   localparam logic [2:0] OPK_ERASE_32K = 3'h4;
   localparam logic [2:0] OPK_ERASE_64K = 3'h5;
   localparam logic [2:0] OPK_ERASE_CHIP = 3'h6;
   localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
   localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [4:0] DUMMY_CYC_0 = 5'h08;
   localparam logic [4:0] DUMMY_CYC_1 = 5'h06;
   localparam logic [4:0] DUMMY_CYC_2 = 5'h08;
   localparam logic [4:0] DUMMY_CYC_3 = 5'h0a;
   localparam logic QUAD_RESET = 1'b0;

   typedef struct packed {
      logic ok;
      logic quad_ok;
      logic [1:0] cls;
      logic [2:0] kind;
      logic has_addr;
      logic force4;
      logic [2:0] alane;
      logic [2:0] dlane;
      logic dummy;
      logic ddr;
      logic quad_on;
   } cmd_s;

   function automatic logic [4:0] dummy_count(input logic [1:0] cfg);
      case (cfg)
         2'h1: dummy_count = DUMMY_CYC_1;
         2'h2: dummy_count = DUMMY_CYC_2;
         2'h3: dummy_count = DUMMY_CYC_3;
         default: dummy_count = DUMMY_CYC_0;
      endcase
   endfunction : dummy_count

   function automatic cmd_s decode(input logic [7:0] op);
      cmd_s c;
      c = '{1'b1, 1'b0, CL_READ, OPK_READ, 1'b1, 1'b0, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0};
      case (op)
         8'h03, 8'h13: c.dummy = 1'b0;
         8'h0b, 8'h0c: c.dummy = 1'b1;
         8'h3b, 8'h3c: c.dlane = 3'h2;
         8'hbb, 8'hbc: {c.alane, c.dlane} = {3'h2, 3'h2};
         8'h6b, 8'h6c: c.dlane = 3'h4;
         8'heb, 8'hec: {c.alane, c.dlane, c.quad_ok} = {3'h4, 3'h4, 1'b1};
         8'h0d, 8'h0e: c.ddr = 1'b1;
         8'hbd, 8'hbe: {c.alane, c.dlane, c.ddr} = {3'h2, 3'h2, 1'b1};
         8'hed, 8'hee: {c.alane, c.dlane, c.ddr, c.quad_ok} = {3'h4, 3'h4, 2'h3};
         8'h02, 8'h12: {c.cls, c.kind, c.quad_ok} = {CL_PROG, OPK_PROGRAM, 1'b1};
         8'h38, 8'h3e: {c.cls, c.kind, c.dlane} = {CL_PROG, OPK_PROGRAM, 3'h4};
         8'h20, 8'h21: {c.cls, c.kind, c.quad_ok} = {CL_ERASE, OPK_ERASE_4K, 1'b1};
         8'h52, 8'h5c: {c.cls, c.kind, c.quad_ok} = {CL_ERASE, OPK_ERASE_32K, 1'b1};
         8'hd8, 8'hdc: {c.cls, c.kind, c.quad_ok} = {CL_ERASE, OPK_ERASE_64K, 1'b1};
         8'h60, 8'hc7: {c.cls, c.kind, c.quad_ok, c.has_addr} =
            {CL_ERASE, OPK_ERASE_CHIP, 2'h2};
         8'h35: {c.cls, c.has_addr, c.quad_ok, c.quad_on} = {CL_MODE, 3'h3};
         8'hf5: {c.cls, c.has_addr, c.quad_ok, c.quad_on} = {CL_MODE, 3'h2};
         default: c.ok = 1'b0;
      endcase
      c.force4 = op inside {8'h13, 8'h0c, 8'h3c, 8'hbc, 8'h6c, 8'hec, 8'h0e, 8'hbe,
         8'hee, 8'h12, 8'h3e, 8'h21, 8'h5c, 8'hdc};
      return c;
   endfunction : decode
endpackage : fcd_pkg

// ---- verilog/link_ev_if.sv ----
// Synchronised link events passed from the pin sampler to the decoder
`timescale 1ns/100ps
interface link_ev_if;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [3:0] io;
   modport src (output sclk_rise, sclk_fall, cs_fall, cs_rise, io);
   modport dst (input sclk_rise, sclk_fall, cs_fall, cs_rise, io);
endinterface : link_ev_if

// ---- verilog/link_sampler.sv ----
// Two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/100ps
module link_sampler (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   // Events
   link_ev_if.src ev
);
   typedef struct packed {
      logic [2:0] sck;
      logic [2:0] cs;
      logic [3:0] io1;
      logic [3:0] io2;
   } samp_s;

   samp_s st;
   samp_s next_st;

   always_comb
   begin
      next_st.sck = {st.sck[1:0], sclk};
      next_st.cs = {st.cs[1:0], cs_n};
      next_st.io1 = io_in;
      next_st.io2 = st.io1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         st <= '{3'h0, 3'h7, 4'h0, 4'h0};
      else
         st <= next_st;
   end

   // Stage zero feeds only stage one; edges come from stages one and two
   assign ev.sclk_rise = st.sck[1] & ~st.sck[2];
   assign ev.sclk_fall = ~st.sck[1] & st.sck[2];
   assign ev.cs_fall = ~st.cs[1] & st.cs[2];
   assign ev.cs_rise = st.cs[1] & ~st.cs[2];
   assign ev.io = st.io2;
endmodule : link_sampler

// ---- verilog/word_fifo.sv ----
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Pointers wrap naturally, so DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic vld;
   } fifo_s;

   fifo_s st;
   fifo_s next_st;
   logic do_push;
   logic do_pop;

   always_comb
   begin
      next_st = st;
      do_push = in_valid & in_ready;
      do_pop = st.vld & out_ready;
      if (do_push)
      begin
         next_st.mem[st.wp] = in_data;
         next_st.wp = st.wp + 1'b1;
      end
      if (do_pop)
         next_st.rp = st.rp + 1'b1;
      next_st.cnt = st.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      next_st.vld = next_st.cnt != '0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign in_ready = st.cnt != (AW + 1)'(DEPTH);
   assign out_valid = st.vld;
   assign out_data = st.mem[st.rp];
endmodule : word_fifo

// ---- testbench/flash_host.sv ----
// Host controller model: drives serial clock, select and data lines
`timescale 1ns/100ps
module flash_host (
   // Link pins
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io,
   // Resolved data lines
   input wire logic [3:0] dev_io
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io = 4'h5;
   end
   task automatic open_frame();
      cs_n = 1'b0;
      #160;
   endtask : open_frame
   // Data set while clock low; unused lanes toggle so nothing looks stable
   task automatic send(input logic [31:0] v, input int n, input int ln);
      logic [3:0] g;
      for (int i = n; i > 0; i -= ln)
      begin
         g = 4'(v >> (i - ln));
         io = ln == 4 ? g : ln == 2 ? {~io[3:2], g[1:0]} : {~io[3:1], g[0]};
         #160 sclk = 1'b1;
         #160 sclk = 1'b0;
      end
   endtask : send
   // Late sample: device output lags a fall by up to three system clocks
   task automatic recv(output logic [7:0] b, input int ln);
      for (int i = 0; i < 8; i += ln)
      begin
         #160 sclk = 1'b1;
         #150 b = ln == 4 ? {b[3:0], dev_io} : ln == 2 ? {b[5:0], dev_io[1:0]} :
            {b[6:0], dev_io[1]};
         #10 sclk = 1'b0;
      end
   endtask : recv
   task automatic close_frame();
      #160 cs_n = 1'b1;
      io = ~io;
      #480;
   endtask : close_frame
endmodule : flash_host

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial flash command decoder
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [1:0] cfg = 2'h0;
   logic wide = 1'b0;
   logic busy = 1'b0;
   logic prog_ready = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic sclk, cs_n, quad, op_valid, cmd_reject, rd_next, prog_valid;
   logic [3:0] host_io, pin, io_out, io_oe;
   logic [2:0] op_kind;
   logic [31:0] op_addr, a;
   logic [7:0] prog_data, b;
   logic [35:0] q_op[$];
   logic [7:0] q_prog[$];
   logic [7:0] eop[8] = '{8'h20, 8'h52, 8'hd8, 8'h21, 8'h5c, 8'hdc, 8'h60, 8'hc7};
   logic [2:0] ek[8] = '{3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
   int na[8] = '{24, 24, 24, 32, 32, 32, 0, 0};
   int dcyc[4] = '{8, 6, 8, 10};
   int err_count = 0;
   int checked = 0;
   int nrd = 0;

   always #20 clk_sys = ~clk_sys;
   // Shared data wires: the device wins where it enables its driver
   assign pin = (io_oe & io_out) | (~io_oe & host_io);

   flash_host host (.sclk(sclk), .cs_n(cs_n), .io(host_io), .dev_io(pin));
   serial_flash_command_decoder dut (
      .clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n),
      .io_in(pin), .io_out(io_out), .io_oe(io_oe),
      .dummy_cfg_lo(cfg[0]), .dummy_cfg_hi(cfg[1]),
      .enter_wide_address_mode(wide), .busy(busy), .quad_command_mode(quad),
      .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr), .cmd_reject(cmd_reject),
      .rd_data(rd_data), .rd_next(rd_next),
      .prog_valid(prog_valid), .prog_data(prog_data), .prog_ready(prog_ready)
   );
   //////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // Unexpected results meet an unknown note and always mismatch
   // Falling edge: registered outputs are settled, clear of the launching edge
   always @(negedge clk_sys)
   begin
      if (rd_next === 1'b1)
         nrd++;
      if (op_valid === 1'b1 || cmd_reject === 1'b1)
         chk("op", q_op.size() != 0 ? q_op.pop_front() : 36'hx,
            cmd_reject === 1'b1 ? {1'b1, 35'h0} : {1'b0, op_kind, op_addr});
      if (prog_valid === 1'b1 && prog_ready === 1'b1)
         chk("prog", q_prog.size() != 0 ? q_prog.pop_front() : 36'hx, 36'(prog_data));
   end
   //////////////////////////////////////////////////
   task automatic head(input logic [7:0] op, input int ln, input logic [31:0] ad,
         input int n, input int nd);
      @(posedge clk_sys);
      #13;
      host.open_frame();
      host.send(32'(op), 8, ln);
      host.send(ad, n, ln);
      host.send($urandom, nd, 1);
   endtask : head
   task automatic rd(input logic [7:0] op, input logic [31:0] ad, input int n, input int nd,
         input int dl);
      int n0;
      @(posedge clk_sys) rd_data <= 8'($urandom);
      q_op.push_back({4'h1, ad});
      head(op, 1, ad, n, nd);
      n0 = nrd;
      host.recv(b, dl);
      chk("rd_byte", 36'(rd_data), 36'(b));
      host.close_frame();
      chk("rd_next", 36'h2, 36'(nrd - n0));
   endtask : rd
   task automatic prog(input logic [7:0] op, input int al, input int dl, input int n,
         input logic rej);
      logic [7:0] d;
      a = 32'($urandom) & 32'h00ffffff;
      q_op.push_back(rej ? {1'b1, 35'h0} : {4'h2, a});
      head(op, al, a, 24, 0);
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         if (i < 8 || !rej)
            q_prog.push_back(d);
         host.send(32'(d), 8, dl);
      end
      host.close_frame();
   endtask : prog
   //////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hc5e56bec));
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clk_sys) cfg <= 2'(c);
         rd(8'h0b, 32'($urandom) & 32'h00ffffff, 24, dcyc[c], 1);
      end
      rd(8'h03, 32'($urandom) & 32'h00ffffff, 24, 0, 1);
      rd(8'h3b, 32'($urandom) & 32'h00ffffff, 24, dcyc[3], 2);
      rd(8'h6b, 32'($urandom) & 32'h00ffffff, 24, dcyc[3], 4);
      @(posedge clk_sys) wide <= 1'b1;
      rd(8'h03, $urandom, 32, 0, 1);
      @(posedge clk_sys) wide <= 1'b0;
      foreach (eop[i])
      begin
         a = na[i] == 0 ? 32'h0 : na[i] == 24 ? 32'($urandom) & 32'h00ffffff : $urandom;
         q_op.push_back({1'b0, ek[i], a});
         head(eop[i], 1, a, na[i], 0);
         host.close_frame();
      end
      q_op.push_back({1'b1, 35'h0});
      head(8'h20, 1, a, 24, 0);
      host.send(32'h0000000a, 4, 1);
      host.close_frame();
      prog(8'h02, 1, 1, 5, 1'b0);
      @(posedge clk_sys) prog_ready <= 1'b1;
      prog(8'h38, 1, 4, 3, 1'b0);
      @(posedge clk_sys) prog_ready <= 1'b0;
      prog(8'h02, 1, 1, 9, 1'b1);
      @(posedge clk_sys) prog_ready <= 1'b1;
      @(posedge clk_sys) busy <= 1'b1;
      head(8'h03, 1, a, 24, 0);
      host.recv(b, 1);
      chk("oe_busy", 36'h0, 36'(io_oe));
      host.close_frame();
      @(posedge clk_sys) busy <= 1'b0;
      head(8'h35, 1, a, 0, 0);
      host.close_frame();
      chk("quad_on", 36'h1, 36'(quad));
      q_op.push_back({4'h3, a & 32'h00ffffff});
      head(8'h20, 4, a & 32'h00ffffff, 24, 0);
      host.close_frame();
      head(8'h0b, 4, a, 24, 8);
      host.recv(b, 1);
      chk("oe_refused", 36'h0, 36'(io_oe));
      host.close_frame();
      head(8'hf5, 4, a, 0, 0);
      host.close_frame();
      chk("quad_off", 36'h0, 36'(quad));
      repeat (20) @(posedge clk_sys);
      chk("pending", 36'h0, 36'(q_op.size() + q_prog.size()));
      wrap_up();
   end
   // About six times the expected length of the run
   initial
   begin
      #2000000;
      err_count++;
      wrap_up();
   end
endmodule : testbench
